// >>> inc/pcdi_consts.svh
// Constants for the parallel configuration data intake link
// What this block does
// - 8-bit ratio 1, or 2 with decompression
// - 16-bit 1/2/4, 32-bit 1/4/8 ratios
// - Host holds each word for ratio clocks
// - First extra clock per word decrypts, the capture clock at ratio 1; the rest only wait
// - Host sends no extra clocks after the last word
// - Narrow modes use only the low lines
// - Mode pins set width, voltage, power-on delay
// - Status released after delay; host waits
`ifndef PCDI_CONSTS_SVH
`define PCDI_CONSTS_SVH

// Clock and timing
`define PCDI_MCLK_HZ 10000000
`define PCDI_POR_FAST_MS 4
`define PCDI_POR_STD_MS 100
`define PCDI_POR_FAST_CYC (`PCDI_POR_FAST_MS * (`PCDI_MCLK_HZ / 1000))
`define PCDI_POR_STD_CYC (`PCDI_POR_STD_MS * (`PCDI_MCLK_HZ / 1000))
`define PCDI_POR_CNT_W 20
`define PCDI_HALF_CYC 4'h4

// Mode select pin fields
`define PCDI_MS_W 5
`define PCDI_MS_WIDTH_LO 0
`define PCDI_MS_WIDTH_HI 1
`define PCDI_MS_FASTPOR 2
`define PCDI_MS_IOSTD_LO 3
`define PCDI_MS_IOSTD_HI 4

// Host register byte offsets
`define PCDI_REG_CTRL 4'h0
`define PCDI_REG_STAT 4'h4
`define PCDI_REG_DATA 4'h8

// Control register fields
`define PCDI_CTRL_WIDTH_LO 0
`define PCDI_CTRL_WIDTH_HI 1
`define PCDI_CTRL_ENC 2
`define PCDI_CTRL_DEC 3
`define PCDI_CTRL_START 4
`define PCDI_CTRL_RST 5'h00

// Status register fields
`define PCDI_STAT_READY 0
`define PCDI_STAT_BUSY 1

// Arbitrary decryption key default
`define PCDI_KEY_DEF 32'hA5C3_5A3C

`endif

// >>> inc/pcdi_link_if.sv
// Link between the configuration host and the device
`timescale 1ns/1ps
`default_nettype none
interface pcdi_link_if;
	logic config_clock;
	logic [31:0] cfg_data;
	logic status_o;
	logic status_oe;
	logic status_ready_n;

	// Open-drain status line with pull-up
	assign status_ready_n = status_oe ? status_o : 1'b1;

	modport dev (
		input config_clock,
		input cfg_data,
		output status_o,
		output status_oe
	);
	modport host (
		output config_clock,
		output cfg_data,
		input status_ready_n
	);
endinterface
`default_nettype wire

// >>> inc/pcdi_pkg.sv
// Types and the clocks-per-word function for the configuration link
`default_nettype none
package pcdi_pkg;
	typedef enum logic [1:0] {
		PCDI_W8,
		PCDI_W16,
		PCDI_W32
	} pcdi_width_t;

	// Configuration clocks needed per data word
	function automatic logic [3:0] pcdi_ratio(pcdi_width_t w, logic enc,
		logic dec);
		logic [3:0] r;
		r = 4'h1;
		case (w)
			PCDI_W8: r = dec ? 4'h2 : 4'h1;
			PCDI_W16: r = dec ? 4'h4 : (enc ? 4'h2 : 4'h1);
			PCDI_W32: r = dec ? 4'h8 : (enc ? 4'h4 : 4'h1);
			default: r = 4'h1;
		endcase
		return r;
	endfunction
endpackage
`default_nettype wire

// >>> rtl/pcdi_device.sv
// Device end: fast parallel load intake of configuration words
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "pcdi_consts.svh"
`default_nettype none
module pcdi_device #(
	parameter int POR_FAST_CYC = `PCDI_POR_FAST_CYC,
	parameter int POR_STD_CYC = `PCDI_POR_STD_CYC,
	parameter logic [31:0] KEY = `PCDI_KEY_DEF
) (
	input wire logic mclk,
	input wire logic arst_n,
	pcdi_link_if.dev link,
	input wire logic [`PCDI_MS_W-1:0] mode_select_pins,
	input wire logic enc_en,
	input wire logic dec_en,
	output logic [31:0] word_o,
	output logic word_valid,
	output logic cfg_ready,
	output logic [1:0] width_o,
	output logic [1:0] io_std_o,
	output logic fast_por_o
);
	logic [`PCDI_MS_W-1:0] ms_s1_ff;
	logic [`PCDI_MS_W-1:0] ms_s2_ff;
	logic strap_done_ff;
	pcdi_pkg::pcdi_width_t width_ff;
	logic [1:0] io_std_ff;
	logic fast_por_ff;
	logic [`PCDI_POR_CNT_W-1:0] por_cnt_ff;
	logic ready_ff;
	logic ck_s1_ff;
	logic ck_s2_ff;
	logic ck_s3_ff;
	logic [31:0] d_s1_ff;
	logic [31:0] d_s2_ff;
	logic enc_s1_ff;
	logic enc_s2_ff;
	logic dec_s1_ff;
	logic dec_s2_ff;
	logic [3:0] cnt_ff;
	logic [31:0] word_ff;
	logic [31:0] out_ff;
	logic valid_ff;
	logic rise;
	logic [3:0] ratio;
	logic [31:0] masked;
	logic [31:0] key_m;
	logic [31:0] lane_m;
	logic [`PCDI_POR_CNT_W-1:0] por_lim;

	// Mode pins keep syncing through reset, so the straps are settled
	// when reset lets go; reset must last at least two clocks
	always_ff @(posedge mclk) begin
		ms_s1_ff <= mode_select_pins;
		ms_s2_ff <= ms_s1_ff;
	end

	// Synchronise feature levels
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			enc_s1_ff <= 1'b0;
			enc_s2_ff <= 1'b0;
			dec_s1_ff <= 1'b0;
			dec_s2_ff <= 1'b0;
		end else begin
			enc_s1_ff <= enc_en;
			enc_s2_ff <= enc_s1_ff;
			dec_s1_ff <= dec_en;
			dec_s2_ff <= dec_s1_ff;
		end
	end

	// Catch the static mode straps once after reset release
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			strap_done_ff <= 1'b0;
			width_ff <= pcdi_pkg::PCDI_W8;
			io_std_ff <= 2'h0;
			fast_por_ff <= 1'b0;
		end else if (!strap_done_ff) begin
			strap_done_ff <= 1'b1;
			case (ms_s2_ff[`PCDI_MS_WIDTH_HI:`PCDI_MS_WIDTH_LO])
				2'h1: width_ff <= pcdi_pkg::PCDI_W16;
				2'h2: width_ff <= pcdi_pkg::PCDI_W32;
				default: width_ff <= pcdi_pkg::PCDI_W8;
			endcase
			io_std_ff <=
				ms_s2_ff[`PCDI_MS_IOSTD_HI:`PCDI_MS_IOSTD_LO];
			fast_por_ff <= ms_s2_ff[`PCDI_MS_FASTPOR];
		end
	end

	// Power-on delay picked by the strap
	assign por_lim = fast_por_ff ? POR_FAST_CYC[`PCDI_POR_CNT_W-1:0] :
		POR_STD_CYC[`PCDI_POR_CNT_W-1:0];

	// Count the power-on delay, then release the status line
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			por_cnt_ff <= '0;
			ready_ff <= 1'b0;
		end else if (strap_done_ff && !ready_ff) begin
			if (por_cnt_ff >= por_lim - 1'b1) begin
				ready_ff <= 1'b1;
			end else begin
				por_cnt_ff <= por_cnt_ff + 1'b1;
			end
		end
	end

	// Hold status low until ready, then let the pull-up win
	assign link.status_o = 1'b0;
	assign link.status_oe = !ready_ff;

	// Synchronise link clock and data into mclk
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ck_s1_ff <= 1'b0;
			ck_s2_ff <= 1'b0;
			ck_s3_ff <= 1'b0;
			d_s1_ff <= '0;
			d_s2_ff <= '0;
		end else begin
			ck_s1_ff <= link.config_clock;
			ck_s2_ff <= ck_s1_ff;
			ck_s3_ff <= ck_s2_ff;
			d_s1_ff <= link.cfg_data;
			d_s2_ff <= d_s1_ff;
		end
	end

	// Rising edge of the configuration clock
	assign rise = ck_s2_ff && !ck_s3_ff;
	assign ratio = pcdi_pkg::pcdi_ratio(width_ff, enc_s2_ff, dec_s2_ff);
	// Key trimmed to the lanes in use, so unused lanes stay zero
	assign key_m = enc_s2_ff ? (KEY & lane_m) : 32'h0000_0000;

	// Only the lines of the selected width carry data
	always_comb begin
		lane_m = 32'hFFFF_FFFF;
		case (width_ff)
			pcdi_pkg::PCDI_W8: lane_m = 32'h0000_00FF;
			pcdi_pkg::PCDI_W16: lane_m = 32'h0000_FFFF;
			default: lane_m = 32'hFFFF_FFFF;
		endcase
	end
	assign masked = d_s2_ff & lane_m;

	// Clock slot counter within one word period
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 4'h0;
		end else if (!ready_ff) begin
			cnt_ff <= 4'h0;
		end else if (rise) begin
			if (cnt_ff >= ratio - 4'h1) begin
				cnt_ff <= 4'h0;
			end else begin
				cnt_ff <= cnt_ff + 4'h1;
			end
		end
	end

	// Capture on the first slot, decrypt in the first extra slot, or at capture when ratio is 1
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			word_ff <= '0;
		end else if (ready_ff && rise) begin
			if (cnt_ff == 4'h0) begin
				word_ff <= masked ^ (ratio == 4'h1 ? key_m : 32'h0000_0000);
			end else if (cnt_ff == 4'h1) begin
				word_ff <= word_ff ^ key_m;
			end
		end
	end

	// Emit the processed word at the last slot of the period
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			out_ff <= '0;
			valid_ff <= 1'b0;
		end else begin
			valid_ff <= 1'b0;
			if (ready_ff && rise && cnt_ff >= ratio - 4'h1) begin
				valid_ff <= 1'b1;
				if (ratio == 4'h1) begin
					out_ff <= masked ^ key_m;
				end else if (cnt_ff == 4'h1) begin
					out_ff <= word_ff ^ key_m;
				end else begin
					out_ff <= word_ff;
				end
			end
		end
	end

	assign word_o = out_ff;
	assign word_valid = valid_ff;
	assign cfg_ready = ready_ff;
	assign width_o = width_ff;
	assign io_std_o = io_std_ff;
	assign fast_por_o = fast_por_ff;
endmodule
`default_nettype wire

// >>> rtl/pcdi_host.sv
// Host end: Avalon-MM driven configuration clock and data source
`timescale 1ns/1ps
`include "pcdi_consts.svh"
`default_nettype none
module pcdi_host (
	input wire logic mclk,
	input wire logic arst_n,
	pcdi_link_if.host link,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	typedef enum logic [2:0] {
		H_IDLE,
		H_WAIT,
		H_READY,
		H_LOW,
		H_HIGH
	} pcdi_hstate_t;

	pcdi_hstate_t state_ff;
	logic [4:0] ctrl_ff;
	logic [31:0] rdata_ff;
	logic rd_pend_ff;
	logic rdy_s1_ff;
	logic rdy_s2_ff;
	logic [3:0] div_ff;
	logic [3:0] cyc_ff;
	logic clk_ff;
	logic [31:0] data_ff;
	logic en;
	logic wr_ok;
	logic data_wr;
	logic [3:0] ratio;
	logic busy;

	assign busy = state_ff == H_LOW || state_ff == H_HIGH;
	assign data_wr = avs_write && avs_address == `PCDI_REG_DATA;
	// Data writes stall until the previous word has been clocked out
	assign avs_waitrequest = (avs_read && !rd_pend_ff) ||
		(data_wr && state_ff != H_READY);
	assign wr_ok = avs_write && !avs_waitrequest;
	assign ratio = pcdi_pkg::pcdi_ratio(pcdi_pkg::pcdi_width_t'(ctrl_ff[1:0]),
		ctrl_ff[`PCDI_CTRL_ENC], ctrl_ff[`PCDI_CTRL_DEC]);

	// Control register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= `PCDI_CTRL_RST;
		end else if (wr_ok && avs_address == `PCDI_REG_CTRL) begin
			ctrl_ff <= avs_writedata[4:0];
		end
	end

	// Registered read data, one wait cycle per read
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rd_pend_ff <= 1'b0;
			rdata_ff <= '0;
		end else if (avs_read && !rd_pend_ff) begin
			rd_pend_ff <= 1'b1;
			case (avs_address)
				`PCDI_REG_CTRL: rdata_ff <= {27'h000_0000, ctrl_ff};
				`PCDI_REG_STAT: rdata_ff <= {30'h0000_0000, busy, rdy_s2_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			rd_pend_ff <= 1'b0;
		end
	end

	// Synchronise the released status line
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdy_s1_ff <= 1'b0;
			rdy_s2_ff <= 1'b0;
		end else begin
			rdy_s1_ff <= link.status_ready_n;
			rdy_s2_ff <= rdy_s1_ff;
		end
	end

	// Half-period enable divider, restarted on each word
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			div_ff <= 4'h0;
		end else if (!busy || en) begin
			div_ff <= 4'h0;
		end else begin
			div_ff <= div_ff + 4'h1;
		end
	end
	assign en = busy && div_ff == `PCDI_HALF_CYC - 4'h1;

	// Link sequencer: wait for release, then ratio clocks per word
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= H_IDLE;
			cyc_ff <= 4'h0;
			clk_ff <= 1'b0;
			data_ff <= '0;
		end else begin
			case (state_ff)
				H_IDLE: begin
					if (ctrl_ff[`PCDI_CTRL_START]) begin
						state_ff <= H_WAIT;
					end
				end
				H_WAIT: begin
					if (rdy_s2_ff) begin
						state_ff <= H_READY;
					end
				end
				H_READY: begin
					if (!ctrl_ff[`PCDI_CTRL_START]) begin
						state_ff <= H_IDLE;
					end else if (wr_ok && data_wr) begin
						data_ff <= avs_writedata;
						cyc_ff <= 4'h0;
						state_ff <= H_LOW;
					end
				end
				H_LOW: begin
					if (en) begin
						clk_ff <= 1'b1;
						state_ff <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (en) begin
						clk_ff <= 1'b0;
						if (cyc_ff >= ratio - 4'h1) begin
							state_ff <= H_READY;
						end else begin
							cyc_ff <= cyc_ff + 4'h1;
							state_ff <= H_LOW;
						end
					end
				end
				default: state_ff <= H_IDLE;
			endcase
		end
	end

	assign link.config_clock = clk_ff;
	assign link.cfg_data = data_ff;
	assign avs_readdata = rdata_ff;
endmodule
`default_nettype wire

// >>> sim/pcdi_asserts.sv
// Timing checks on the wires between host and device
`timescale 1ns/1ps
`default_nettype none
module pcdi_asserts (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic config_clock,
	input wire logic [31:0] cfg_data,
	input wire logic status_o,
	input wire logic status_oe,
	input wire logic status_ready_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// High phase of the link clock, then its fall
	sequence hi_phase_s;
		config_clock[*4] ##1 !config_clock;
	endsequence
	// Low phase of the link clock
	sequence lo_phase_s;
		!config_clock[*4];
	endsequence
	hi_phase_a: assert property ($rose(config_clock) |-> hi_phase_s)
		else $error("link clock high phase wrong");
	lo_phase_a: assert property ($fell(config_clock) |-> lo_phase_s)
		else $error("link clock low phase short");
	rise_gap_a: assert property (
		$rose(config_clock) |=> !$rose(config_clock)[*7])
		else $error("link clock rises too close");
	no_early_a: assert property (config_clock |-> status_ready_n)
		else $error("link clock before release");
	data_move_a: assert property (
		$changed(cfg_data) |-> !config_clock && status_ready_n)
		else $error("data moved at bad time");
	data_hold_a: assert property (
		$rose(config_clock) |=> $stable(cfg_data)[*3])
		else $error("data not held while high");
	rel_hold_a: assert property (
		$rose(status_ready_n) |=> status_ready_n[*8])
		else $error("status line pulled again");
	od_low_a: assert property (
		!status_ready_n |-> status_oe && !status_o)
		else $error("status line low undriven");
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Bench joining host and device, with a word model
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [31:0] KEY = 32'h1357_9BDF; // Arbitrary test key
	localparam int POR_F = 20;
	localparam int POR_S = 50;
	logic mclk, arst_n, avs_read, avs_write, enc_en, dec_en, waitreq;
	logic word_valid, cfg_ready, fast_por_o, clk_q;
	logic [3:0] avs_address;
	logic [4:0] ms;
	logic [1:0] width_o, io_std_o;
	logic [31:0] avs_writedata, avs_readdata, rd, d, msk, word_o;
	logic [31:0] exp_q[$];
	int failures, tests_run, seed, rises, por_n;
	pcdi_link_if link ();
	pcdi_device #(.POR_FAST_CYC(POR_F), .POR_STD_CYC(POR_S), .KEY(KEY))
		u_pcdi_device (.mclk(mclk), .arst_n(arst_n), .link(link),
		.mode_select_pins(ms), .enc_en(enc_en), .dec_en(dec_en),
		.word_o(word_o), .word_valid(word_valid), .cfg_ready(cfg_ready),
		.width_o(width_o), .io_std_o(io_std_o), .fast_por_o(fast_por_o));
	pcdi_host u_pcdi_host (.mclk(mclk), .arst_n(arst_n), .link(link),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(waitreq));
	pcdi_asserts u_pcdi_asserts (.mclk(mclk), .arst_n(arst_n),
		.config_clock(link.config_clock), .cfg_data(link.cfg_data),
		.status_o(link.status_o), .status_oe(link.status_oe),
		.status_ready_n(link.status_ready_n));
	// Clock of 100 ns
	always #50 mclk = ~mclk;
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s exp %h got %h", what, e, s);
		end
	endtask
	// One Avalon cycle, held until waitrequest is seen low
	task automatic bus(input logic [3:0] a, input logic w,
		input logic [31:0] wd);
		int n;
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= wd;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (waitreq !== 1'b0 && n < 3000);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 3000) begin
			failures++;
			$display("ERROR bus timeout");
			tally_and_finish();
		end
	endtask
	// Count link clock rises and compare each delivered word
	always @(posedge mclk) begin
		clk_q <= link.config_clock;
		if (link.config_clock === 1'b1 && clk_q === 1'b0)
			rises++;
		// Clocks out of reset with the status line still held low
		if (arst_n === 1'b1 && link.status_ready_n === 1'b0)
			por_n++;
		if (word_valid === 1'b1 && exp_q.size() > 0)
			chk("word", exp_q.pop_front() & msk, word_o);
		else if (word_valid === 1'b1)
			chk("extra word", 32'h0, 32'h1);
	end
	// One strap setting: reset, start, poll release, three words
	task automatic run(input logic [1:0] w, input logic e, input logic c);
		int r, k, p;
		r = w == 0 ? (c ? 2 : 1) :
			w == 1 ? (c ? 4 : e ? 2 : 1) : (c ? 8 : e ? 4 : 1);
		msk = w == 0 ? 32'h0000_00FF : w == 1 ? 32'h0000_FFFF : 32'hFFFF_FFFF;
		d = $random(seed);
		// Strap edge plus the selected power-on delay
		p = (d[2] ? POR_F : POR_S) + 1;
		por_n = 0;
		arst_n <= 1'b0;
		ms <= {d[4:2], w};
		enc_en <= e;
		dec_en <= c;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		chk("status", 32'h0, {31'h0, link.status_ready_n});
		bus(4'h0, 1'b1, {27'h0, 1'b1, c, e, w});
		rd = 32'h0;
		for (k = 0; k < 500 && rd[0] !== 1'b1; k++)
			bus(4'h4, 1'b0, 32'h0);
		chk("released", 32'h1, {31'h0, rd[0]});
		chk("ready", 32'h1, {31'h0, cfg_ready});
		chk("por delay", 32'(p), 32'(por_n));
		chk("straps", {27'h0, ms},
			{27'h0, io_std_o, fast_por_o, width_o});
		rises = 0;
		for (k = 0; k < 3; k++) begin
			d = $random(seed);
			exp_q.push_back(e ? d ^ KEY : d);
			bus(4'h8, 1'b1, d);
		end
		for (k = 0; k < 400 && exp_q.size() > 0; k++)
			@(posedge mclk);
		repeat (24) @(posedge mclk);
		chk("words left", 32'h0, 32'(exp_q.size()));
		chk("rises", 32'(3 * r), 32'(rises));
		exp_q.delete();
		$display("test width %0d enc %0d dec %0d done", w, e, c);
	endtask
	initial begin
		mclk = 1'b0;
		// Starts high so the first reset gives a real falling edge
		arst_n = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		ms = 5'h00;
		enc_en = 1'b0;
		dec_en = 1'b0;
		msk = 32'h0;
		seed = 32'h56ea63e3;
		failures = 0;
		tests_run = 0;
		rises = 0;
		por_n = 0;
		for (int w = 0; w < 3; w++)
			for (int e = 0; e < 2; e++)
				for (int c = 0; c < 2; c++)
					run(w[1:0], e[0], c[0]);
		bus(4'hC, 1'b0, 32'h0);
		chk("unmapped", 32'h0, rd);
		tally_and_finish();
	end
endmodule
`default_nettype wire
